/* design/debug_trace_pkg.sv */
// Constants, register map and encodings of the trigger and trace unit.
// Assumes a 32-bit APB slave port and a 50 MHz system clock.
package debug_trace_pkg;
  localparam int NUM_TRIG = 4;
  localparam int TRIG_BITS = 2;
  localparam int BUF_DEPTH = 256;
  localparam int BUF_AW = 8;
  localparam int FRAME_W = 40;
  localparam int SEQ_W = 5;
  // Register byte offsets
  localparam logic [11:0] TRACE_CTRL = 12'h000;
  localparam logic [11:0] TRACE_STAT = 12'h004;
  localparam logic [11:0] BRK_VEC = 12'h008;
  localparam logic [11:0] TBUF_IDX = 12'h00c;
  localparam logic [11:0] TBUF_LO = 12'h010;
  localparam logic [11:0] TBUF_HI = 12'h014;
  localparam logic [11:0] TRIG_BASE = 12'h100;
  // Trace control bits
  localparam int CTL_START = 0;
  localparam int CTL_STOP = 1;
  localparam int CTL_STOP_FULL = 2;
  localparam int CTL_EXT = 3;
  localparam int CTL_EXEC = 4;
  localparam int CTL_DATA = 5;
  localparam int CTL_MODE_LSB = 6;
  localparam int CTL_CLEAR = 9;
  localparam int CTL_RESUME = 10;
  // Status bits
  localparam int ST_ON = 0;
  localparam int ST_FULL = 1;
  localparam int ST_BRK_SEEN = 2;
  localparam int ST_BRK = 3;
  localparam int ST_EXT_BUSY = 4;
  localparam int ST_PEND = 5;
  // Trigger control bits
  localparam int TC_EN = 0;
  localparam int TC_BUS = 1;
  localparam int TC_ADDR = 2;
  localparam int TC_DATA = 3;
  localparam int TC_RD = 4;
  localparam int TC_WR = 5;
  localparam int TC_ARMED = 6;
  localparam int TC_RANGE = 7;
  localparam int TC_ACT_LSB = 8;
  localparam int TC_TGT_LSB = 12;
  // Reset values
  localparam logic [6:0] TCTL_RST = 7'h00;
  localparam logic [31:0] BRK_VEC_RST = 32'h0000_0000;
  localparam logic [15:0] TRIG_CTRL_RST = 16'h0000;
  typedef enum logic [2:0] {
    ACT_BREAK, ACT_EXT, ACT_TRACE_ON, ACT_TRACE_OFF, ACT_SAMPLE, ACT_ARM
  } action_type;
  typedef enum logic [2:0] {
    FT_NONE, FT_EXEC, FT_DADDR, FT_DDATA, FT_SADDR, FT_SDATA
  } frame_type;
  typedef enum logic [2:0] {
    DM_LD_ADDR, DM_ST_ADDR, DM_ALL_ADDR, DM_LD_DATA,
    DM_LD_BOTH, DM_ST_BOTH, DM_ALL_BOTH
  } data_mode_type;
endpackage

/* design/debug_trigger_trace_unit.sv */
// Trigger and trace unit of the debug module: bus watch, actions, trace.
// Assumes processor buses on CLK, test-port access over APB, probe clock
// arriving asynchronously on PROBE_CLK.
//
// Overview of operation
// RULE1 - Instruction address compared each instruction, breaks on match
// RULE2 - Breakpoints are triggers with break action
// RULE3 - Conditions on one bus are ANDed
// RULE4 - Address match on instruction and data bus
// RULE5 - Data value match on data bus
// RULE6 - Read cycle and write cycle qualifiers
// RULE7 - Break halts processor, debug takes control
// RULE8 - External action drives trigger output pin
// RULE9 - Trace on and trace off actions
// RULE10 - Sample stores one bus sample, data only
// RULE11 - Armed condition waits for arm action
// RULE12 - Two-level sequence through arming
// RULE13 - Paired triggers form address/data range
// RULE14 - Trace instruction bus, data bus, or both
// RULE15 - Seven data trace filter modes
// RULE16 - Optional stop on full, processor continues
// RULE17 - Host starts and stops trace manually
// RULE18 - Trace buffer read only over test port
// RULE19 - Trace may go to external probe
// RULE20 - Flow-change frames with instruction counts
// RULE21 - Every selected data access stored
// RULE22 - Execution frames first, data kept ordered
// RULE23 - Break redirects to configured break address
// RULE24 - System clock at least four times probe
// RULE25 - Host programs triggers, refused during capture
// RULE26 - Full and break status readable by host
//
// Local design decisions: the register offsets and register access over APB.
`timescale 1ns/1ps
module debug_trigger_trace_unit
  import debug_trace_pkg::*;
(
  input wire logic CLK,
  input wire logic RST_B,
  input wire logic CE,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic I_VALID,
  input wire logic I_FLOW,
  input wire logic [31:0] I_ADDR,
  input wire logic D_VALID,
  input wire logic D_WRITE,
  input wire logic [31:0] D_ADDR,
  input wire logic [31:0] D_DATA,
  output logic STALL,
  output logic BREAK_REQ,
  output logic [31:0] BREAK_ADDR,
  output logic TRIG_OUT,
  input wire logic PROBE_CLK,
  output logic [FRAME_W-1:0] PROBE_DATA,
  output logic PROBE_VALID
);
  logic [15:0] t_ctrl_q [NUM_TRIG];
  logic [31:0] t_addr_q [NUM_TRIG];
  logic [31:0] t_data_q [NUM_TRIG];
  logic [NUM_TRIG-1:0] arm_q, arm_set, fire;
  logic [6:0] tctl_q;
  logic trace_on_q, full_q, brk_q, brk_seen_q, trig_q;
  logic [31:0] brk_vec_q, prdata_q, rdata;
  logic [BUF_AW-1:0] wr_q, rd_q;
  logic [FRAME_W-1:0] mem [BUF_DEPTH];
  logic [SEQ_W-1:0] seq_q;
  logic [1:0] pend_v_q;
  logic [FRAME_W-1:0] pend0_q, pend1_q, ext_q, probe_data_q;
  logic ext_full_q, probe_valid_q, ps1_q, ps2_q, ps3_q, ready_q, err_q;

  logic acc, done, wr_acc, t_hit, rerr, resume;
  logic [11:0] t_off;
  logic [TRIG_BITS-1:0] t_idx;
  logic any_brk, any_ext, any_on, any_off, any_samp;
  logic i_take, d_take, writable, sink_rdy, ex_req, ex_stall;
  logic d_stall, wr_ex, wr_pend, mem_we, ext_we, gen_d;
  logic want_a, want_d, probe_rise, man_start, man_stop, clr_buf;
  logic [FRAME_W-1:0] wr_frame;

  // APB slave, one wait state so read data comes from a flip-flop
  assign acc = PSEL & PENABLE;
  assign PREADY = acc & ready_q & CE;
  assign done = PREADY;
  assign wr_acc = done & PWRITE;
  assign PRDATA = prdata_q;
  assign PSLVERR = PREADY & err_q;
  assign t_off = PADDR - TRIG_BASE;
  assign t_hit = (t_off[11:6] == 6'h00) && (t_off[3:2] != 2'b11);
  assign t_idx = t_off[4 +: TRIG_BITS];
  assign man_start = wr_acc & (PADDR == TRACE_CTRL) & PWDATA[CTL_START];
  assign man_stop = wr_acc & (PADDR == TRACE_CTRL) & PWDATA[CTL_STOP];
  assign clr_buf = wr_acc & (PADDR == TRACE_CTRL) & PWDATA[CTL_CLEAR];
  assign resume = wr_acc & (PADDR == TRACE_CTRL) & PWDATA[CTL_RESUME];

  always_comb begin
    rdata = 32'h0000_0000;
    rerr = 1'b0;
    if (t_hit) begin
      unique case (t_off[3:2])
        2'b00: rdata = {16'h0000, t_ctrl_q[t_idx]};
        2'b01: rdata = t_addr_q[t_idx];
        default: rdata = t_data_q[t_idx];
      endcase
      rerr = PWRITE & trace_on_q; // RULE25
    end else begin
      unique case (PADDR)
        TRACE_CTRL: rdata = {23'h000000, tctl_q, 2'b00};
        TRACE_STAT: rdata = {26'h0000000, (pend_v_q != 2'b00), ext_full_q,
                             brk_q, brk_seen_q, full_q, trace_on_q}; // RULE26
        BRK_VEC: rdata = brk_vec_q;
        TBUF_IDX: rdata = {8'h00, wr_q, 8'h00, rd_q};
        TBUF_LO: rdata = mem[rd_q][31:0]; // RULE18
        TBUF_HI: rdata = {24'h000000, mem[rd_q][FRAME_W-1:32]};
        default: rerr = 1'b1;
      endcase
    end
  end

  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      ready_q <= 1'b0;
      prdata_q <= 32'h0000_0000;
      err_q <= 1'b0;
    end else if (CE) begin
      ready_q <= acc & ~ready_q;
      if (acc & ~ready_q) begin
        prdata_q <= PWRITE ? 32'h0000_0000 : rdata;
        err_q <= rerr;
      end
    end
  end

  // Trigger configuration, written only while capture is off
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      for (int i = 0; i < NUM_TRIG; i++) begin
        t_ctrl_q[i] <= TRIG_CTRL_RST;
        t_addr_q[i] <= 32'h0000_0000;
        t_data_q[i] <= 32'h0000_0000;
      end
    end else if (CE && wr_acc && t_hit && !trace_on_q) begin // RULE25
      unique case (t_off[3:2])
        2'b00: t_ctrl_q[t_idx] <= PWDATA[15:0];
        2'b01: t_addr_q[t_idx] <= PWDATA;
        default: t_data_q[t_idx] <= PWDATA;
      endcase
    end
  end

  // Per-trigger condition match
  for (genvar g = 0; g < NUM_TRIG; g++) begin : g_trig
    localparam int P = g ^ 1;
    logic [15:0] c;
    logic dbus;
    logic rng;
    logic ha;
    logic hd;
    logic [31:0] a;
    assign c = t_ctrl_q[g];
    assign dbus = c[TC_BUS];
    assign rng = c[TC_RANGE] & dbus;
    assign a = dbus ? D_ADDR : I_ADDR; // RULE4
    assign ha = rng ? (a >= t_addr_q[g] && a <= t_addr_q[P]) :
                (a == t_addr_q[g]); // RULE13 RULE1
    assign hd = rng ? (D_DATA >= t_data_q[g] && D_DATA <= t_data_q[P]) :
                (D_DATA == t_data_q[g]); // RULE13
    assign fire[g] = c[TC_EN] & (dbus ? d_take : i_take) &
                     (~c[TC_ADDR] | ha) &
                     (~c[TC_DATA] | (dbus & hd)) & // RULE5
                     (~c[TC_RD] | (dbus & ~D_WRITE)) & // RULE6
                     (~c[TC_WR] | (dbus & D_WRITE)) & // RULE6 RULE3
                     (~c[TC_ARMED] | arm_q[g]); // RULE11
  end

  // Collect actions of all firing triggers
  always_comb begin
    any_brk = 1'b0;
    any_ext = 1'b0;
    any_on = 1'b0;
    any_off = 1'b0;
    any_samp = 1'b0;
    arm_set = '0;
    for (int i = 0; i < NUM_TRIG; i++) begin
      if (fire[i]) begin
        unique case (t_ctrl_q[i][TC_ACT_LSB +: 3])
          ACT_BREAK: any_brk = 1'b1; // RULE2
          ACT_EXT: any_ext = 1'b1;
          ACT_TRACE_ON: any_on = 1'b1; // RULE9
          ACT_TRACE_OFF: any_off = 1'b1; // RULE9
          ACT_SAMPLE: any_samp = any_samp | t_ctrl_q[i][TC_BUS]; // RULE10
          ACT_ARM: arm_set[t_ctrl_q[i][TC_TGT_LSB +: TRIG_BITS]] = 1'b1;
          default: ;
        endcase
      end
    end
  end

  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      arm_q <= '0;
    end else if (CE) begin
      for (int j = 0; j < NUM_TRIG; j++) begin
        if (arm_set[j]) begin
          arm_q[j] <= 1'b1; // RULE12
        end else if (wr_acc && t_hit && !trace_on_q && t_idx == j
                     && t_off[3:2] == 2'b00) begin
          arm_q[j] <= 1'b0;
        end
      end
    end
  end

  // Break, external trigger and break vector
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      brk_q <= 1'b0;
      brk_seen_q <= 1'b0;
      trig_q <= 1'b0;
      brk_vec_q <= BRK_VEC_RST;
    end else if (CE) begin
      if (any_brk) begin
        brk_q <= 1'b1; // RULE7
      end else if (resume) begin
        brk_q <= 1'b0;
      end
      if (any_brk) begin
        brk_seen_q <= 1'b1; // RULE26
      end else if (wr_acc && PADDR == TRACE_STAT && PWDATA[ST_BRK_SEEN]) begin
        brk_seen_q <= 1'b0;
      end
      trig_q <= any_ext; // RULE8
      if (wr_acc && PADDR == BRK_VEC) begin
        brk_vec_q <= PWDATA;
      end
    end
  end
  assign BREAK_REQ = brk_q; // RULE7
  assign BREAK_ADDR = brk_vec_q; // RULE23
  assign TRIG_OUT = trig_q;

  // Trace control
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      tctl_q <= TCTL_RST;
      trace_on_q <= 1'b0;
    end else if (CE) begin
      if (wr_acc && PADDR == TRACE_CTRL) begin
        tctl_q <= PWDATA[CTL_MODE_LSB+2:CTL_STOP_FULL];
      end
      if (any_off || man_stop) begin
        trace_on_q <= 1'b0; // RULE9 RULE17
      end else if (any_on || man_start) begin
        trace_on_q <= 1'b1; // RULE9 RULE17
      end
    end
  end

  // Frame generation and write arbitration
  assign writable = tctl_q[CTL_EXT-2] |
                    ~(tctl_q[CTL_STOP_FULL-2] & full_q); // RULE16
  assign sink_rdy = tctl_q[CTL_EXT-2] ? ~ext_full_q : 1'b1;
  assign ex_req = I_VALID & I_FLOW & trace_on_q & tctl_q[CTL_EXEC-2] &
                  writable; // RULE14 RULE20
  assign ex_stall = ex_req & ~sink_rdy;
  assign d_stall = D_VALID & (pend_v_q != 2'b00); // RULE21
  assign STALL = ex_stall | d_stall;
  assign i_take = I_VALID & ~ex_stall;
  assign d_take = D_VALID & ~d_stall;
  assign wr_ex = ex_req & sink_rdy; // RULE22
  assign wr_pend = ~ex_req & pend_v_q[0] & sink_rdy; // RULE22
  assign wr_frame = wr_ex ? {FT_EXEC, seq_q, I_ADDR} : pend0_q;
  assign mem_we = (wr_ex | wr_pend) & ~tctl_q[CTL_EXT-2] & writable;
  assign ext_we = (wr_ex | wr_pend) & tctl_q[CTL_EXT-2]; // RULE19
  assign gen_d = trace_on_q & tctl_q[CTL_DATA-2] & writable; // RULE14

  always_comb begin
    want_a = 1'b0;
    want_d = 1'b0;
    unique case (tctl_q[CTL_MODE_LSB-2 +: 3]) // RULE15
      DM_LD_ADDR: want_a = ~D_WRITE;
      DM_ST_ADDR: want_a = D_WRITE;
      DM_ALL_ADDR: want_a = 1'b1;
      DM_LD_DATA: want_d = ~D_WRITE;
      DM_LD_BOTH: begin
        want_a = ~D_WRITE;
        want_d = ~D_WRITE;
      end
      DM_ST_BOTH: begin
        want_a = D_WRITE;
        want_d = D_WRITE;
      end
      DM_ALL_BOTH: begin
        want_a = 1'b1;
        want_d = 1'b1;
      end
      default: ;
    endcase
  end

  // Pending data frames keep their order behind execution frames
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      pend_v_q <= 2'b00;
      pend0_q <= '0;
      pend1_q <= '0;
    end else if (CE) begin
      if (d_take && any_samp && writable) begin
        pend_v_q <= 2'b11; // RULE10
        pend0_q <= {FT_SADDR, 4'h0, D_WRITE, D_ADDR};
        pend1_q <= {FT_SDATA, 4'h0, D_WRITE, D_DATA};
      end else if (d_take && gen_d && (want_a || want_d)) begin
        pend_v_q <= {want_a & want_d, 1'b1}; // RULE21
        pend0_q <= want_a ? {FT_DADDR, 4'h0, D_WRITE, D_ADDR} :
                   {FT_DDATA, 4'h0, D_WRITE, D_DATA};
        pend1_q <= {FT_DDATA, 4'h0, D_WRITE, D_DATA};
      end else if (wr_pend) begin
        pend_v_q <= {1'b0, pend_v_q[1]};
        pend0_q <= pend1_q;
      end
    end
  end

  // Instructions since last flow-change frame
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      seq_q <= '0;
    end else if (CE) begin
      if (wr_ex) begin
        seq_q <= '0; // RULE20
      end else if (i_take && trace_on_q && tctl_q[CTL_EXEC-2] && !(&seq_q)) begin
        seq_q <= seq_q + 1'b1;
      end
    end
  end

  // On-chip trace memory
  always_ff @(posedge CLK) begin
    if (CE && mem_we) begin
      mem[wr_q] <= wr_frame;
    end
  end

  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      wr_q <= '0;
      full_q <= 1'b0;
      rd_q <= '0;
    end else if (CE) begin
      if (mem_we) begin
        wr_q <= wr_q + 1'b1;
      end else if (clr_buf) begin
        wr_q <= '0;
      end
      if (mem_we && (&wr_q)) begin
        full_q <= 1'b1; // RULE16
      end else if (clr_buf) begin
        full_q <= 1'b0;
      end
      if (wr_acc && PADDR == TBUF_IDX) begin
        rd_q <= PWDATA[BUF_AW-1:0];
      end else if (done && !PWRITE && PADDR == TBUF_LO) begin
        rd_q <= rd_q + 1'b1; // RULE18
      end
    end
  end

  // Probe output, advanced on each rising probe clock edge
  assign probe_rise = ps2_q & ~ps3_q;
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      ps1_q <= 1'b0;
      ps2_q <= 1'b0;
      ps3_q <= 1'b0;
      ext_full_q <= 1'b0;
      ext_q <= '0;
      probe_data_q <= '0;
      probe_valid_q <= 1'b0;
    end else if (CE) begin
      ps1_q <= PROBE_CLK;
      ps2_q <= ps1_q;
      ps3_q <= ps2_q;
      if (ext_we) begin
        ext_q <= wr_frame; // RULE19
        ext_full_q <= 1'b1;
      end else if (probe_rise) begin
        ext_full_q <= 1'b0;
      end
      if (probe_rise) begin
        probe_data_q <= ext_q;
        probe_valid_q <= ext_full_q;
      end
    end
  end
  assign PROBE_DATA = probe_data_q;
  assign PROBE_VALID = probe_valid_q;
endmodule

/* sim/debug_trace_properties.sv */
// Concurrent checks on the ports of the trigger and trace unit.
// Assumes binding to the design top with CE held high.
`timescale 1ns/1ps
module debug_trace_properties
  import debug_trace_pkg::*;
(
  input wire logic CLK,
  input wire logic RST_B,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic PREADY,
  input wire logic PSLVERR,
  input wire logic I_VALID,
  input wire logic D_VALID,
  input wire logic STALL,
  input wire logic BREAK_REQ,
  input wire logic [31:0] BREAK_ADDR,
  input wire logic TRIG_OUT,
  input wire logic PROBE_CLK,
  input wire logic [FRAME_W-1:0] PROBE_DATA,
  input wire logic PROBE_VALID
);
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_B);
  logic resume;
  assign resume = PREADY && PWRITE && PADDR == TRACE_CTRL
    && PWDATA[CTL_RESUME];
  a_ready_wait: assert property (
    PREADY |-> $past(PSEL && PENABLE && !PREADY))
    else $error("Ready without its wait state");
  a_err_ready: assert property (
    PSLVERR |-> PREADY) else $error("Error outside completion");
  a_unmapped_err: assert property (
    PREADY && PADDR == 12'h018 |-> PSLVERR)
    else $error("Unmapped access not refused");
  a_brk_vector: assert property (
    PREADY && PWRITE && PADDR == BRK_VEC |=> BREAK_ADDR == $past(PWDATA))
    else $error("Break address not updated");
  a_brk_cause: assert property (
    $rose(BREAK_REQ) |-> $past((I_VALID || D_VALID) && !STALL))
    else $error("Break without a taken access");
  a_brk_hold: assert property (
    BREAK_REQ && !resume |=> BREAK_REQ) else $error("Break dropped");
  a_brk_resume: assert property (
    resume && !I_VALID && !D_VALID |=> !BREAK_REQ)
    else $error("Resume ignored");
  a_trig_cause: assert property (
    TRIG_OUT |-> $past((I_VALID || D_VALID) && !STALL))
    else $error("Trigger pulse without a taken access");
  a_probe_edge: assert property (
    $changed(PROBE_VALID) || $changed(PROBE_DATA)
    |-> $past(PROBE_CLK, 3) || $past(PROBE_CLK, 4))
    else $error("Probe output moved off a probe edge");
endmodule
bind debug_trigger_trace_unit debug_trace_properties
  debug_trace_properties_inst (.CLK(CLK), .RST_B(RST_B), .PSEL(PSEL),
  .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA),
  .PREADY(PREADY), .PSLVERR(PSLVERR), .I_VALID(I_VALID),
  .D_VALID(D_VALID), .STALL(STALL), .BREAK_REQ(BREAK_REQ),
  .BREAK_ADDR(BREAK_ADDR), .TRIG_OUT(TRIG_OUT), .PROBE_CLK(PROBE_CLK),
  .PROBE_DATA(PROBE_DATA), .PROBE_VALID(PROBE_VALID));

/* sim/probe_model.sv */
// Behavioural debug probe: makes the probe clock, takes trace frames.
// Assumes frame outputs settle a few system clocks after each rise.
`timescale 1ns/1ps
module probe_model
  import debug_trace_pkg::*;
(
  input wire logic run,
  input wire logic [FRAME_W-1:0] data,
  input wire logic valid,
  output logic pclk,
  output logic [FRAME_W-1:0] last,
  output logic got
);
  initial begin
    pclk = 1'b0;
    last = '0;
    got = 1'b0;
    #3;
    forever begin
      #80;
      pclk = run ? ~pclk : 1'b0;
    end
  end
  always @(posedge pclk) begin
    if (valid) begin
      last <= data;
      got <= 1'b1;
    end
  end
endmodule

/* sim/debug_trigger_trace_unit_tb.sv */
// Self-checking bench for the trigger and trace unit.
// Assumes the bound checker and the probe model beside the design.
`timescale 1ns/1ps
module debug_trigger_trace_unit_tb
  import debug_trace_pkg::*;
();
  logic CLK = 1'b0, RST_B = 1'b0, CE = 1'b1, run = 1'b0, got;
  logic PSEL = 1'b0, PENABLE = 1'b0, PWRITE = 1'b0;
  logic [11:0] PADDR = 12'h000;
  logic [31:0] PWDATA = 32'h0, I_ADDR = 32'h0, D_ADDR = 32'h0;
  logic I_VALID = 1'b0, I_FLOW = 1'b0, D_VALID = 1'b0, D_WRITE = 1'b0;
  logic [31:0] D_DATA = 32'h0, PRDATA, BREAK_ADDR, rd;
  logic PREADY, PSLVERR, STALL, BREAK_REQ, TRIG_OUT, PROBE_CLK, er;
  logic PROBE_VALID;
  logic [FRAME_W-1:0] PROBE_DATA, last;
  int err_count = 0, total_checks = 0, cyc = 0;
  always #10 CLK = ~CLK;
  debug_trigger_trace_unit debug_trigger_trace_unit_inst (
    .CLK(CLK), .RST_B(RST_B), .CE(CE), .PSEL(PSEL), .PENABLE(PENABLE),
    .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA),
    .PREADY(PREADY), .PSLVERR(PSLVERR), .I_VALID(I_VALID),
    .I_FLOW(I_FLOW), .I_ADDR(I_ADDR), .D_VALID(D_VALID),
    .D_WRITE(D_WRITE), .D_ADDR(D_ADDR), .D_DATA(D_DATA), .STALL(STALL),
    .BREAK_REQ(BREAK_REQ), .BREAK_ADDR(BREAK_ADDR), .TRIG_OUT(TRIG_OUT),
    .PROBE_CLK(PROBE_CLK), .PROBE_DATA(PROBE_DATA),
    .PROBE_VALID(PROBE_VALID));
  probe_model probe_model_inst (.run(run), .data(PROBE_DATA),
    .valid(PROBE_VALID), .pclk(PROBE_CLK), .last(last), .got(got));
  task automatic close_out;
    $display("Checks %0d, mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic chk(input logic [39:0] s, input logic [39:0] e);
    total_checks++;
    if (s !== e) begin
      err_count++;
      $display("BAD t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    @(posedge CLK);
    PSEL <= 1'b1;
    PWRITE <= w;
    PADDR <= a;
    PWDATA <= d;
    @(posedge CLK);
    PENABLE <= 1'b1;
    do begin
      @(posedge CLK);
      n++;
    end while (PREADY !== 1'b1 && n < 50);
    if (n >= 50) err_count++;
    rd = PRDATA;
    er = PSLVERR;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
    @(negedge CLK);
  endtask
  task automatic bus(input logic i, input logic w, input logic [31:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    @(posedge CLK);
    I_VALID <= i;
    I_FLOW <= i;
    I_ADDR <= a;
    D_VALID <= !i;
    D_WRITE <= w;
    D_ADDR <= a;
    D_DATA <= d;
    do begin
      @(negedge CLK);
      n++;
    end while (STALL !== 1'b0 && n < 50);
    if (n >= 50) err_count++;
    @(posedge CLK);
    I_VALID <= 1'b0;
    D_VALID <= 1'b0;
    @(negedge CLK);
  endtask
  task automatic trig(input int n, input logic [15:0] c,
                      input logic [31:0] a, input logic [31:0] d);
    apb(1'b1, TRIG_BASE + 12'(16 * n), {16'h0000, c});
    apb(1'b1, TRIG_BASE + 12'(16 * n + 4), a);
    apb(1'b1, TRIG_BASE + 12'(16 * n + 8), d);
  endtask
  task automatic t_regs;
    apb(1'b0, TRACE_CTRL, 32'h0);
    chk(rd, 32'(TCTL_RST) << 2);
    apb(1'b0, TRIG_BASE, 32'h0);
    chk(rd, 32'(TRIG_CTRL_RST));
    apb(1'b0, BRK_VEC, 32'h0);
    chk(rd, BRK_VEC_RST);
    apb(1'b1, BRK_VEC, 32'h0000_4000);
    apb(1'b0, BRK_VEC, 32'h0);
    chk(rd, 32'h0000_4000);
    apb(1'b0, 12'h018, 32'h0);
    chk({er, rd}, 33'h1_0000_0000);
    $display("Register test done");
  endtask
  task automatic t_brk;
    trig(0, 16'h0005, 32'h0000_0100, 32'h0);
    bus(1'b1, 1'b0, 32'h0000_0104, 32'h0);
    chk(BREAK_REQ, 1'b0);
    bus(1'b1, 1'b0, 32'h0000_0100, 32'h0);
    chk(BREAK_REQ, 1'b1);
    chk(BREAK_ADDR, 32'h0000_4000);
    apb(1'b0, TRACE_STAT, 32'h0);
    chk(rd[3:2], 2'b11);
    apb(1'b1, TRACE_CTRL, 32'h0000_0400);
    chk(BREAK_REQ, 1'b0);
    trig(0, 16'h0000, 32'h0, 32'h0);
    $display("Break test done");
  endtask
  task automatic t_cond;
    trig(1, 16'h0127, 32'h0000_0200, 32'h0);
    bus(1'b0, 1'b0, 32'h0000_0200, 32'h0);
    chk(TRIG_OUT, 1'b0);
    bus(1'b0, 1'b1, 32'h0000_0204, 32'h0);
    chk(TRIG_OUT, 1'b0);
    bus(1'b0, 1'b1, 32'h0000_0200, 32'h0);
    chk(TRIG_OUT, 1'b1);
    trig(1, 16'h0000, 32'h0, 32'h0);
    trig(2, 16'h014b, 32'h0, 32'h0000_0055);
    trig(3, 16'h2505, 32'h0000_0300, 32'h0);
    bus(1'b0, 1'b0, 32'h0000_0010, 32'h0000_0055);
    chk(TRIG_OUT, 1'b0);
    bus(1'b1, 1'b0, 32'h0000_0300, 32'h0);
    bus(1'b0, 1'b0, 32'h0000_0010, 32'h0000_0055);
    chk(TRIG_OUT, 1'b1);
    $display("Condition test done");
  endtask
  task automatic t_trace;
    apb(1'b1, TRACE_CTRL, 32'h0000_0031);
    apb(1'b0, TRACE_STAT, 32'h0);
    chk(rd[ST_ON], 1'b1);
    apb(1'b1, TRIG_BASE, 32'h0000_0001);
    chk(er, 1'b1);
    bus(1'b1, 1'b0, 32'h0000_0400, 32'h0);
    bus(1'b0, 1'b0, 32'h0000_0500, 32'h0000_0077);
    apb(1'b1, TRACE_CTRL, 32'h0000_0002);
    apb(1'b0, TRACE_STAT, 32'h0);
    chk(rd[ST_ON], 1'b0);
    apb(1'b0, TBUF_HI, 32'h0);
    chk(rd[7:5], FT_EXEC);
    apb(1'b0, TBUF_LO, 32'h0);
    chk(rd, 32'h0000_0400);
    apb(1'b0, TBUF_HI, 32'h0);
    chk(rd[7:5], FT_DADDR);
    apb(1'b0, TBUF_LO, 32'h0);
    chk(rd, 32'h0000_0500);
    $display("Trace test done");
  endtask
  task automatic t_probe;
    int n;
    n = 0;
    run <= 1'b1;
    apb(1'b1, TRACE_CTRL, 32'h0000_0019);
    bus(1'b1, 1'b0, 32'h0000_0600, 32'h0);
    while (got !== 1'b1 && n < 200) begin
      @(negedge CLK);
      n++;
    end
    chk({last[39:37], last[31:0]}, {FT_EXEC, 32'h0000_0600});
    apb(1'b1, TRACE_CTRL, 32'h0000_0002);
    run <= 1'b0;
    $display("Probe test done");
  endtask
  always @(posedge CLK) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_count++;
      close_out;
    end
  end
  initial begin
    repeat (16) @(posedge CLK);
    RST_B <= 1'b1;
    t_regs;
    t_brk;
    t_cond;
    t_trace;
    t_probe;
    close_out;
  end
endmodule
